//--- hdl/iroic_pkg.sv
// Shared constants and types of the image region crop block
package iroic_pkg;

  // ==========================================================
  // Widths
  localparam int DIM_W  = 17;
  localparam int PIX_W  = 8;
  localparam int ADDR_W = 6;

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL    = 6'h00;
  localparam logic [5:0] OFF_STATUS  = 6'h04;
  localparam logic [5:0] OFF_HSTART  = 6'h08;
  localparam logic [5:0] OFF_VSTART  = 6'h0C;
  localparam logic [5:0] OFF_COLS    = 6'h10;
  localparam logic [5:0] OFF_ROWS    = 6'h14;
  localparam logic [5:0] OFF_FFCOLS  = 6'h18;
  localparam logic [5:0] OFF_FFROWS  = 6'h1C;
  localparam logic [5:0] OFF_EFFCOLS = 6'h20;
  localparam logic [5:0] OFF_EFFROWS = 6'h24;

  // ==========================================================
  // Field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_ORG_LSB  = 1;
  localparam int STAT_REJ_BIT  = 0;
  localparam int STAT_RUN_BIT  = 1;
  localparam int STAT_BUSY_BIT = 2;

  // ==========================================================
  // Reset values
  localparam logic [16:0] RST_HSTART = 17'h00000;
  localparam logic [16:0] RST_VSTART = 17'h00000;
  localparam logic [16:0] RST_COLS   = 17'h00400;
  localparam logic [16:0] RST_ROWS   = 17'h00400;
  localparam logic [16:0] RST_FFCOLS = 17'h00400;
  localparam logic [16:0] RST_FFROWS = 17'h00400;

  // ==========================================================
  // Limits
  localparam logic [17:0] MAX_COLS    = 18'h08000;
  localparam logic [17:0] MAX_ROWS    = 18'h10000;
  localparam logic [16:0] MIRROR_COLS = 17'h02000;
  localparam logic [16:0] MIN_COLS    = 17'h00008;
  localparam logic [16:0] MIN_ROWS    = 17'h00002;
  localparam logic [16:0] MAX_HSTART  = 17'h07FF8;
  localparam logic [16:0] MAX_VSTART  = 17'h0FFFF;
  localparam logic [34:0] DRAM_PIXELS = 35'h0_4000_0000;
  localparam logic [7:0]  PAD_PIXEL   = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ORG_TOP_LEFT     = 2'b00,
    ORG_TOP_RIGHT    = 2'b01,
    ORG_BOTTOM_LEFT  = 2'b10,
    ORG_BOTTOM_RIGHT = 2'b11
  } iroic_origin_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT_SOF = 3'b001,
    ST_ACTIVE   = 3'b010,
    ST_PAD      = 3'b011,
    ST_REPLAY   = 3'b100
  } iroic_state_t;

endpackage : iroic_pkg

//--- hdl/iroic_cfg_if.sv
// Region configuration carried to the legality checker
`timescale 1ns/1ps
interface iroic_cfg_if;
  logic [16:0]              hstart;
  logic [16:0]              vstart;
  logic [16:0]              cols;
  logic [16:0]              rows;
  logic [16:0]              ffcols;
  logic [16:0]              ffrows;
  iroic_pkg::iroic_origin_t origin;
  logic                     ok;
  logic [16:0]              eff_cols;
  logic [16:0]              eff_rows;

  modport src (output hstart, vstart, cols, rows, ffcols, ffrows, origin, input ok, eff_cols, eff_rows);
  modport chk (input hstart, vstart, cols, rows, ffcols, ffrows, origin, output ok, eff_cols, eff_rows);
endinterface : iroic_cfg_if

//--- hdl/iroic_check.sv
// Legality check and effective frame size of one region configuration
`timescale 1ns/1ps
module iroic_check (
  // Configuration under test
  iroic_cfg_if.chk cfg
);
  logic        hmir;
  logic        vmir;
  logic [17:0] hend;
  logic [17:0] vend;
  logic [34:0] dram_prod;
  logic [34:0] dram_need;

  // ==========================================================
  // Mirroring, effective size and all range tests
  always_comb begin
    hmir = cfg.origin[0];
    vmir = cfg.origin[1];
    hend = {1'b0, cfg.hstart} + {1'b0, cfg.cols};
    vend = {1'b0, cfg.vstart} + {1'b0, cfg.rows};
    cfg.eff_cols = hmir ? cfg.ffcols : hend[16:0];
    cfg.eff_rows = vmir ? cfg.ffrows : vend[16:0];
    dram_prod = {18'h00000, cfg.eff_cols} * {18'h00000, cfg.ffrows};
    dram_need = {dram_prod[33:0], 1'b0};
    cfg.ok = 1'b1;
    // Per-field ranges and step sizes
    if (cfg.cols < iroic_pkg::MIN_COLS || {1'b0, cfg.cols} > iroic_pkg::MAX_COLS) cfg.ok = 1'b0;
    if (cfg.cols[2:0] != 3'h0 || cfg.hstart[2:0] != 3'h0) cfg.ok = 1'b0;
    if (cfg.rows < iroic_pkg::MIN_ROWS || {1'b0, cfg.rows} > iroic_pkg::MAX_ROWS) cfg.ok = 1'b0;
    if (cfg.hstart > iroic_pkg::MAX_HSTART) cfg.ok = 1'b0;
    if (cfg.vstart > iroic_pkg::MAX_VSTART) cfg.ok = 1'b0;
    if (cfg.ffrows < iroic_pkg::MIN_ROWS || {1'b0, cfg.ffrows} > iroic_pkg::MAX_ROWS) cfg.ok = 1'b0;
    if (cfg.ffcols < iroic_pkg::MIN_COLS || {1'b0, cfg.ffcols} > iroic_pkg::MAX_COLS) cfg.ok = 1'b0;
    if (cfg.ffcols[2:0] != 3'h0) cfg.ok = 1'b0;
    // Joint limits of offset plus size, mirror line width and DRAM space
    if (hend > iroic_pkg::MAX_COLS) cfg.ok = 1'b0;
    if (vend > iroic_pkg::MAX_ROWS) cfg.ok = 1'b0;
    if (hmir && (hend > {1'b0, cfg.ffcols} || cfg.ffcols > iroic_pkg::MIRROR_COLS)) cfg.ok = 1'b0;
    if (vmir && vend > {1'b0, cfg.ffrows}) cfg.ok = 1'b0;
    if (vmir && dram_need > iroic_pkg::DRAM_PIXELS) cfg.ok = 1'b0;
  end

endmodule : iroic_check

//--- hdl/iroic_count.sv
// Column and line position of each incoming pixel
`timescale 1ns/1ps
module iroic_count (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Pixel beat
  input  wire logic        fire,
  input  wire logic        sof,
  input  wire logic        sol,
  // Position of the beat
  output logic      [16:0] col,
  output logic      [16:0] line
);
  logic [16:0] col_reg;
  logic [16:0] line_reg;
  logic [16:0] col_next;
  logic [16:0] line_next;

  // ==========================================================
  // Column restarts at each frame and line start, line at each frame start
  always_comb begin
    col  = (sof || sol) ? 17'h00000 : 17'(col_reg + 17'h00001);
    line = sof ? 17'h00000 : (sol ? 17'(line_reg + 17'h00001) : line_reg);
    col_next  = fire ? col : col_reg;
    line_next = fire ? line : line_reg;
  end

  // Position registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      col_reg  <= 17'h00000;
      line_reg <= 17'h00000;
    end else begin
      col_reg  <= col_next;
      line_reg <= line_next;
    end
  end

endmodule : iroic_count

//--- hdl/iroic_top.sv
// Region-of-interest crop with Avalon-MM configuration registers
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
// ==========================================================
// Contract
// - Large frames: output exactly the region pixels
// - Small frames: pad lines, rows may truncate
// - Reject horizontal start plus columns above 32768
// - Reject vertical start plus rows above 65536
// - Columns, horizontal start step 8; rows step 1
// - Dependent ranges; rejected writes flagged to software
// - Region writes only while acquisition stopped
// - Horizontal mirror: start plus columns within full width
// - Vertical mirror: start plus rows within full height
// - Vertical mirror: full frame must fit DRAM
// - Horizontal mirror limits line width to 8192
// - No vertical mirror: effective height is start plus rows
// - Full-frame rows 2 to 65536, reset 1024
// - Columns 8 to 32768 step 8, reset 1024
// - Rows 2 to 65536, reset 1024
// - Horizontal start 0 to 32760 step 8
// - Output frame size equals region size
// - Origin corner selects mirroring, reset top-left
// - No mirror: effective width is start plus columns
// - Vertical mirror double-buffers two frames in DRAM
module iroic_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM register slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Camera pixel stream
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_sof,
  input  wire logic        in_sol,
  output logic             in_ready,
  // Region pixel stream to DMA
  output logic             out_valid,
  output logic      [7:0]  out_data,
  output logic             out_sof,
  output logic             out_eol,
  output logic             out_eof,
  // Output frame size and state
  output logic      [16:0] out_frame_cols,
  output logic      [16:0] out_frame_rows,
  output logic             acq_running
);
  // ==========================================================
  // Declarations
  iroic_cfg_if cand_if ();
  iroic_cfg_if live_if ();

  logic                     wait_reg, wait_next;
  logic [31:0]              rdata_reg, rdata_next;
  logic                     run_reg, run_next;
  logic                     rej_reg, rej_next;
  iroic_pkg::iroic_origin_t origin_reg, origin_next;
  logic [16:0]              hstart_reg, hstart_next, vstart_reg, vstart_next;
  logic [16:0]              cols_reg, cols_next, rows_reg, rows_next;
  logic [16:0]              ffcols_reg, ffcols_next, ffrows_reg, ffrows_next;
  logic [31:0]              rd_mux, mask, new_word;
  logic                     wr_take, cfg_sel;

  iroic_pkg::iroic_state_t  state_reg, state_next;
  logic [16:0]              ocol_reg, ocol_next, orow_reg, orow_next;
  logic                     ready_reg, ready_next, pad_eof_reg, pad_eof_next;
  logic [7:0]               held_data_reg, held_data_next;
  logic                     held_sof_reg, held_sof_next, held_sol_reg, held_sol_next;
  logic                     ov_reg, ov_next, osof_reg, osof_next;
  logic                     oeol_reg, oeol_next, oeof_reg, oeof_next;
  logic [7:0]               od_reg, od_next;
  logic                     beat_fire, beat_sof, beat_sol, cnt_fire;
  logic [7:0]               beat_data;
  logic [16:0]              pcol, pline;
  logic [17:0]              hend, vend;
  logic                     in_region, last_col, last_row, open, busy;

  // ==========================================================
  // Submodules
  iroic_check u_cand_check (.cfg(cand_if));
  iroic_check u_live_check (.cfg(live_if));

  iroic_count u_count (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fire  (cnt_fire),
    .sof   (beat_sof),
    .sol   (beat_sol),
    .col   (pcol),
    .line  (pline)
  );

  // Live configuration seen by the checker
  assign live_if.hstart = hstart_reg;
  assign live_if.vstart = vstart_reg;
  assign live_if.cols   = cols_reg;
  assign live_if.rows   = rows_reg;
  assign live_if.ffcols = ffcols_reg;
  assign live_if.ffrows = ffrows_reg;
  assign live_if.origin = origin_reg;

  // ==========================================================
  // Register read mux
  always_comb begin
    rd_mux = 32'h00000000;
    busy   = (state_reg == iroic_pkg::ST_ACTIVE) || (state_reg == iroic_pkg::ST_PAD)
             || (state_reg == iroic_pkg::ST_REPLAY);
    unique case (avs_address)
      iroic_pkg::OFF_CTRL:    rd_mux = {29'h00000000, origin_reg, run_reg};
      iroic_pkg::OFF_STATUS:  rd_mux = {29'h00000000, busy, run_reg, rej_reg};
      iroic_pkg::OFF_HSTART:  rd_mux = {15'h0000, hstart_reg};
      iroic_pkg::OFF_VSTART:  rd_mux = {15'h0000, vstart_reg};
      iroic_pkg::OFF_COLS:    rd_mux = {15'h0000, cols_reg};
      iroic_pkg::OFF_ROWS:    rd_mux = {15'h0000, rows_reg};
      iroic_pkg::OFF_FFCOLS:  rd_mux = {15'h0000, ffcols_reg};
      iroic_pkg::OFF_FFROWS:  rd_mux = {15'h0000, ffrows_reg};
      iroic_pkg::OFF_EFFCOLS: rd_mux = {15'h0000, live_if.eff_cols};
      iroic_pkg::OFF_EFFROWS: rd_mux = {15'h0000, live_if.eff_rows};
      default:                rd_mux = 32'h00000000;
    endcase
  end

  // Candidate configuration: live values with the written field merged in
  always_comb begin
    mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    new_word = (rd_mux & ~mask) | (avs_writedata & mask);
    cand_if.hstart = hstart_reg;
    cand_if.vstart = vstart_reg;
    cand_if.cols   = cols_reg;
    cand_if.rows   = rows_reg;
    cand_if.ffcols = ffcols_reg;
    cand_if.ffrows = ffrows_reg;
    cand_if.origin = origin_reg;
    cfg_sel = 1'b1;
    unique case (avs_address)
      iroic_pkg::OFF_HSTART: cand_if.hstart = new_word[16:0];
      iroic_pkg::OFF_VSTART: cand_if.vstart = new_word[16:0];
      iroic_pkg::OFF_COLS:   cand_if.cols   = new_word[16:0];
      iroic_pkg::OFF_ROWS:   cand_if.rows   = new_word[16:0];
      iroic_pkg::OFF_FFCOLS: cand_if.ffcols = new_word[16:0];
      iroic_pkg::OFF_FFROWS: cand_if.ffrows = new_word[16:0];
      iroic_pkg::OFF_CTRL: begin
        cand_if.origin = iroic_pkg::iroic_origin_t'(new_word[2:1]);
        cfg_sel        = (new_word[2:1] != origin_reg);
      end
      default:               cfg_sel = 1'b0;
    endcase
  end

  // ==========================================================
  // Bus handshake and configuration next state
  always_comb begin
    wait_next   = 1'b1;
    rdata_next  = rdata_reg;
    run_next    = run_reg;
    rej_next    = rej_reg;
    origin_next = origin_reg;
    hstart_next = hstart_reg;
    vstart_next = vstart_reg;
    cols_next   = cols_reg;
    rows_next   = rows_reg;
    ffcols_next = ffcols_reg;
    ffrows_next = ffrows_reg;
    wr_take     = avs_write && !wait_reg;
    // Request seen with waitrequest high: answer in the next cycle
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next  = 1'b0;
      rdata_next = avs_read ? rd_mux : rdata_reg;
    end
    if (wr_take) begin
      if (avs_address == iroic_pkg::OFF_STATUS && avs_byteenable[0]) begin
        rej_next = rej_reg & ~avs_writedata[iroic_pkg::STAT_REJ_BIT];
      end
      if (avs_address == iroic_pkg::OFF_CTRL) begin
        run_next = new_word[iroic_pkg::CTRL_RUN_BIT];
      end
      if (cfg_sel) begin
        if (!run_reg && cand_if.ok) begin
          origin_next = cand_if.origin;
          hstart_next = cand_if.hstart;
          vstart_next = cand_if.vstart;
          cols_next   = cand_if.cols;
          rows_next   = cand_if.rows;
          ffcols_next = cand_if.ffcols;
          ffrows_next = cand_if.ffrows;
        end else begin
          rej_next = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Pixel beat: replayed held beat or a fresh input beat
  always_comb begin
    beat_fire = (state_reg == iroic_pkg::ST_REPLAY) || (in_valid && ready_reg);
    beat_data = (state_reg == iroic_pkg::ST_REPLAY) ? held_data_reg : in_data;
    beat_sof  = (state_reg == iroic_pkg::ST_REPLAY) ? held_sof_reg : in_sof;
    beat_sol  = (state_reg == iroic_pkg::ST_REPLAY) ? held_sol_reg : in_sol;
    hend      = {1'b0, hstart_reg} + {1'b0, cols_reg};
    vend      = {1'b0, vstart_reg} + {1'b0, rows_reg};
    in_region = (pcol >= hstart_reg) && ({1'b0, pcol} < hend)
                && (pline >= vstart_reg) && ({1'b0, pline} < vend);
    last_col  = (ocol_reg == 17'(cols_reg - 17'h00001));
    last_row  = (orow_reg == 17'(rows_reg - 17'h00001));
    open      = (ocol_reg != 17'h00000) || (orow_reg != 17'h00000);
    // A held beat advances the position only on its replay, never twice
    cnt_fire  = beat_fire && !(state_reg == iroic_pkg::ST_ACTIVE && open
                && (beat_sof || (beat_sol && ocol_reg != 17'h00000)));
  end

  // Crop state machine
  always_comb begin
    state_next     = state_reg;
    ocol_next      = ocol_reg;
    orow_next      = orow_reg;
    ready_next     = ready_reg;
    pad_eof_next   = pad_eof_reg;
    held_data_next = held_data_reg;
    held_sof_next  = held_sof_reg;
    held_sol_next  = held_sol_reg;
    ov_next        = 1'b0;
    od_next        = od_reg;
    osof_next      = 1'b0;
    oeol_next      = 1'b0;
    oeof_next      = 1'b0;
    unique case (state_reg)
      iroic_pkg::ST_IDLE: begin
        ready_next = 1'b1;
        ocol_next  = 17'h00000;
        orow_next  = 17'h00000;
        if (run_reg) state_next = iroic_pkg::ST_WAIT_SOF;
      end
      iroic_pkg::ST_WAIT_SOF, iroic_pkg::ST_ACTIVE, iroic_pkg::ST_REPLAY: begin
        ready_next = 1'b1;
        if (state_reg == iroic_pkg::ST_REPLAY) state_next = iroic_pkg::ST_ACTIVE;
        if (beat_fire) begin
          if (state_reg == iroic_pkg::ST_ACTIVE && open && (beat_sof || (beat_sol && ocol_reg != 17'h00000))) begin
            // Short line or early frame: hold the beat, close the output first
            held_data_next = beat_data;
            held_sof_next  = beat_sof;
            held_sol_next  = beat_sol;
            ready_next     = 1'b0;
            if (ocol_reg != 17'h00000) begin
              state_next   = iroic_pkg::ST_PAD;
              pad_eof_next = beat_sof;
            end else begin
              oeof_next  = 1'b1;
              orow_next  = 17'h00000;
              state_next = iroic_pkg::ST_REPLAY;
            end
          end else if (state_reg != iroic_pkg::ST_WAIT_SOF || beat_sof) begin
            state_next = iroic_pkg::ST_ACTIVE;
            if (in_region) begin
              ov_next   = 1'b1;
              od_next   = beat_data;
              osof_next = !open;
              oeol_next = last_col;
              if (last_col) begin
                ocol_next = 17'h00000;
                if (last_row) begin
                  oeof_next  = 1'b1;
                  orow_next  = 17'h00000;
                  state_next = iroic_pkg::ST_WAIT_SOF;
                end else begin
                  orow_next = 17'(orow_reg + 17'h00001);
                end
              end else begin
                ocol_next = 17'(ocol_reg + 17'h00001);
              end
            end
          end
        end
      end
      iroic_pkg::ST_PAD: begin
        ov_next   = 1'b1;
        od_next   = iroic_pkg::PAD_PIXEL;
        oeol_next = last_col;
        if (last_col) begin
          ocol_next  = 17'h00000;
          state_next = iroic_pkg::ST_REPLAY;
          if (pad_eof_reg || last_row) begin
            oeof_next = 1'b1;
            orow_next = 17'h00000;
          end else begin
            orow_next = 17'(orow_reg + 17'h00001);
          end
        end else begin
          ocol_next = 17'(ocol_reg + 17'h00001);
        end
      end
      default: state_next = iroic_pkg::ST_IDLE;
    endcase
    // Stopping acquisition abandons the frame
    if (!run_reg && state_reg != iroic_pkg::ST_IDLE) begin
      state_next = iroic_pkg::ST_IDLE;
      ready_next = 1'b1;
    end
  end

  // ==========================================================
  // All registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_reg      <= 1'b1;
      rdata_reg     <= 32'h00000000;
      run_reg       <= 1'b0;
      rej_reg       <= 1'b0;
      origin_reg    <= iroic_pkg::ORG_TOP_LEFT;
      hstart_reg    <= iroic_pkg::RST_HSTART;
      vstart_reg    <= iroic_pkg::RST_VSTART;
      cols_reg      <= iroic_pkg::RST_COLS;
      rows_reg      <= iroic_pkg::RST_ROWS;
      ffcols_reg    <= iroic_pkg::RST_FFCOLS;
      ffrows_reg    <= iroic_pkg::RST_FFROWS;
      state_reg     <= iroic_pkg::ST_IDLE;
      ocol_reg      <= 17'h00000;
      orow_reg      <= 17'h00000;
      ready_reg     <= 1'b0;
      pad_eof_reg   <= 1'b0;
      held_data_reg <= 8'h00;
      held_sof_reg  <= 1'b0;
      held_sol_reg  <= 1'b0;
      ov_reg        <= 1'b0;
      od_reg        <= 8'h00;
      osof_reg      <= 1'b0;
      oeol_reg      <= 1'b0;
      oeof_reg      <= 1'b0;
    end else begin
      wait_reg      <= wait_next;
      rdata_reg     <= rdata_next;
      run_reg       <= run_next;
      rej_reg       <= rej_next;
      origin_reg    <= origin_next;
      hstart_reg    <= hstart_next;
      vstart_reg    <= vstart_next;
      cols_reg      <= cols_next;
      rows_reg      <= rows_next;
      ffcols_reg    <= ffcols_next;
      ffrows_reg    <= ffrows_next;
      state_reg     <= state_next;
      ocol_reg      <= ocol_next;
      orow_reg      <= orow_next;
      ready_reg     <= ready_next;
      pad_eof_reg   <= pad_eof_next;
      held_data_reg <= held_data_next;
      held_sof_reg  <= held_sof_next;
      held_sol_reg  <= held_sol_next;
      ov_reg        <= ov_next;
      od_reg        <= od_next;
      osof_reg      <= osof_next;
      oeol_reg      <= oeol_next;
      oeof_reg      <= oeof_next;
    end
  end

  // ==========================================================
  // Outputs straight from registers
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign in_ready        = ready_reg;
  assign out_valid       = ov_reg;
  assign out_data        = od_reg;
  assign out_sof         = osof_reg;
  assign out_eol         = oeol_reg;
  assign out_eof         = oeof_reg;
  assign out_frame_cols  = cols_reg;
  assign out_frame_rows  = rows_reg;
  assign acq_running     = run_reg;

endmodule : iroic_top

//--- testbench/iroic_monitor.sv
// Port checker of the region crop block
`timescale 1ns/1ps
module iroic_monitor (
  // Clock, reset, bus and stream flags
  input wire logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest, in_valid, in_ready,
  input wire logic        out_valid, out_sof, out_eol, out_eof, acq_running,
  // Frame size
  input wire logic [16:0] out_frame_cols, out_frame_rows
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Bus answer, lock and stream framing
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  cfg_lock_a: assert property (acq_running |=> $stable(out_frame_cols) && $stable(out_frame_rows))
    else $error("frame size moved while running");
  stop_quiet_a: assert property (!acq_running [*3] |-> !out_valid && !out_eof)
    else $error("output while stopped");
  mark_valid_a: assert property (out_sof || out_eol |-> out_valid)
    else $error("marker without pixel");
  eof_line_a: assert property (out_eof && out_valid |-> out_eol)
    else $error("frame end inside a line");
  eof_pulse_a: assert property (out_eof |=> !out_eof)
    else $error("frame end held");
  pix_cause_a: assert property (out_valid |-> $past(in_valid && in_ready) || !$past(in_ready))
    else $error("pixel without beat");
  // Main scenarios reached
  cover property (out_valid && out_sof);
  cover property (out_valid && !in_ready);
  cover property (out_eof && out_valid);
endmodule : iroic_monitor
bind iroic_top iroic_monitor i_iroic_monitor (.mclk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .in_valid, .in_ready, .out_valid, .out_sof, .out_eol, .out_eof, .acq_running, .out_frame_cols, .out_frame_rows);

//--- testbench/iroic_cam.sv
// Camera model: raster frames of a given size on the pixel link
`timescale 1ns/1ps
module iroic_cam (
  // Clock, frame request and size
  input wire logic        mclk, go, in_ready,
  input wire logic [16:0] w, h,
  // Pixel link and activity
  output logic            in_valid, in_sof, in_sol, busy,
  output logic [7:0]      in_data
);
  logic [16:0] c, l;
  initial begin
    {in_valid, in_sof, in_sol, busy, in_data, c, l} = '0;
  end
  // Step on each taken beat, hold it while refused, scramble data when idle
  always @(posedge mclk) begin
    if (in_valid && in_ready) begin
      c = (c == w - 17'h00001) ? 17'h00000 : c + 17'h00001;
      if (c == 17'h00000) l = l + 17'h00001;
    end
    if (go && !busy) begin
      busy = 1'b1;
      c = 17'h00000;
      l = 17'h00000;
    end
    if (l == h) busy = 1'b0;
    in_valid <= busy;
    in_sof <= busy && c == 17'h00000 && l == 17'h00000;
    in_sol <= busy && c == 17'h00000 && l != 17'h00000;
    in_data <= busy ? 8'(c + 17'h00003 * l) : ~in_data;
  end
endmodule : iroic_cam

//--- testbench/iroic_test.sv
// Self-checking bench of the region crop block
`timescale 1ns/1ps
module iroic_test;
  logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, go = 0;
  logic [5:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, hs, vs;
  logic        avs_waitrequest, in_valid, in_sof, in_sol, in_ready, busy;
  logic        out_valid, out_sof, out_eol, out_eof, acq_running;
  logic [7:0]  in_data, out_data;
  logic [16:0] w = 17'h00020, h = 17'h00006, ocols, orows;
  logic [10:0] q[$];
  logic [47:0] rt[6] = '{48'h10_0000C_00400, 48'h08_07FF8_00000, 48'h08_00004_00000,
                         48'h14_00001_00400, 48'h0C_0FFFF_00000, 48'h1C_00001_00400};
  integer      n_fail = 0, total_checks = 0, seed = 32'h3825, cyc = 0;
  always #20 mclk = ~mclk;
  iroic_top i_iroic_top (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .in_valid, .in_data, .in_sof, .in_sol, .in_ready,
    .out_valid, .out_data, .out_sof, .out_eol, .out_eof, .out_frame_cols(ocols), .out_frame_rows(orows), .acq_running);
  iroic_cam i_iroic_cam (.mclk, .go, .in_ready, .w, .h, .in_valid, .in_sof, .in_sol, .busy, .in_data);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic setup(input logic [31:0] a, b, c, d);
    bus(1, 6'h00, 0);
    bus(1, 6'h08, a);
    bus(1, 6'h0C, b);
    bus(1, 6'h10, c);
    bus(1, 6'h14, d);
    bus(1, 6'h00, 1);
    chk("frame cols", c, ocols);
    chk("frame rows", d, orows);
  endtask : setup
  // Note the expected region pixels, then send one camera frame
  task automatic frame(input logic [31:0] cw, a, b, c, d);
    logic [31:0] x;
    for (int r = 0; r < d; r++)
      for (int k = 0; k < c; k++) begin
        x = a + k;
        q.push_back({r == 0 && k == 0, k == c - 1, r == d - 1 && k == c - 1, x < cw ? 8'(x + 3 * (b + r)) : 8'h00});
      end
    w <= cw[16:0];
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    while (busy || q.size() > 0) @(negedge mclk);
    $display("frame test done, width %0d", cw);
  endtask : frame
  // Output watcher and hang limit
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      print_verdict;
    end
    if (out_valid === 1'b1 || out_eof === 1'b1)
      chk("pixel", q.size() > 0 ? q.pop_front() : 11'h7FF, {out_sof, out_eol, out_eof, out_data});
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    chk("frame cols", 32'h400, ocols);
    bus(0, 6'h00, 0);
    chk("origin", 0, rd);
    foreach (rt[i]) begin
      bus(0, rt[i][45:40], 0);
      chk("reset value", rt[i][19:0], rd);
      bus(1, rt[i][45:40], rt[i][39:20]);
      bus(0, rt[i][45:40], 0);
      chk("kept value", rt[i][19:0], rd);
      bus(0, 6'h04, 0);
      chk("reject flag", 1, rd[0]);
      bus(1, 6'h04, 1);
    end
    bus(1, 6'h00, 2);
    bus(1, 6'h10, 32'h408);
    bus(0, 6'h10, 0);
    chk("mirror width", 32'h400, rd);
    bus(1, 6'h00, 6);
    bus(1, 6'h14, 32'h401);
    bus(0, 6'h14, 0);
    chk("mirror height", 32'h400, rd);
    bus(1, 6'h00, 0);
    bus(1, 6'h1C, 32'h7D0);
    bus(1, 6'h18, 32'h7D0);
    bus(0, 6'h24, 0);
    chk("eff rows", 32'h400, rd);
    bus(0, 6'h20, 0);
    chk("eff cols", 32'h400, rd);
    $display("register test done");
    hs = {$random(seed)} % 3 * 8;
    vs = {$random(seed)} % 3;
    setup(hs, vs, 16, 3);
    bus(1, 6'h10, 8);
    bus(0, 6'h10, 0);
    chk("locked cols", 16, rd);
    chk("running", 1, acq_running);
    frame(32, hs, vs, 16, 3);
    setup(8, 0, 16, 2);
    frame(16, 8, 0, 16, 2);
    bus(1, 6'h00, 0);
    chk("left", 0, q.size());
    print_verdict;
  end
endmodule : iroic_test
